// File: logic/hpm_top.sv
/*
 * Host port upper pin mux: three pins that carry chip select or address
 * bit 10, host or transmit request, acknowledge or receive request, or
 * serve as general-purpose bits 13, 14 and 15.
 * Assumes pins are resolved outside from output and active-low enable,
 * and that the host port core runs on MCLK.
 */
// Our own choices: the plain strobed port and the address map.
//
// How it works
// R1 - Non-multiplexed host mode: first pin is chip select, polarity set.
// R2 - Multiplexed host mode: first pin is host address bit 10.
// R3 - General-purpose mode: bits 13 and 15 take direction from own bits.
// R4 - Bit 14 is general-purpose only in multiplexed mode with GPIO chosen.
// R5 - Single-request host mode: second pin drives request, polarity, drive.
// R6 - Double-request host mode: second pin drives transmit request.
// R7 - Single-request mode: third pin samples acknowledge, set polarity.
// R8 - Double-request mode: third pin drives receive request, polarity, drive.
// R9 - Control register picks host or GPIO; direction register sets bits.
// R10 - In reset all three pins are released to high impedance.
`timescale 1ns/1ps
`default_nettype none
module hpm_top
    import hpm_pkg::*;
(
    // Clock and reset
    input  wire logic          MCLK,
    input  wire logic          RESET_N,
    // Register port
    input  wire logic [AW-1:0] ADDR,
    input  wire logic [DW-1:0] WDATA,
    input  wire logic          WR,
    input  wire logic          RD,
    output logic      [DW-1:0] RDATA,
    // Host port core side
    input  wire logic          HOST_REQUEST_OUT,
    input  wire logic          TRANSMIT_REQUEST_OUT,
    input  wire logic          RECEIVE_REQUEST_OUT,
    output logic               HOST_CHIP_SELECT,
    output logic               HOST_ADDR_BIT10,
    output logic               HOST_ACKNOWLEDGE_IN,
    // Pins: bit 13, bit 14, bit 15
    input  wire logic [NP-1:0] PIN_I,
    output logic      [NP-1:0] PIN_O,
    output logic      [NP-1:0] PIN_OE_N
);

    hpm_cfg_if cfg ();

    hpm_regs u_regs (
        .clk   (MCLK),
        .rst_n (RESET_N),
        .addr  (ADDR),
        .wdata (WDATA),
        .wr    (WR),
        .rd    (RD),
        .rdata (RDATA),
        .cfg   (cfg)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Turns an active-high level into pin level; pol high means active high.
    function automatic logic f_pol(input logic v, input logic pol);
        f_pol = v ^ ~pol;
    endfunction

    // Returns {output, enable_n} for a request pin.
    function automatic logic [1:0] f_drv(input logic lvl, input logic od);
        f_drv = od ? {1'b0, lvl} : {lvl, 1'b0};
    endfunction

    logic hen, mux, dbl, od;
    assign hen = cfg.ctrl[C_HOST_EN];
    assign mux = cfg.ctrl[C_MUX_BUS];
    assign dbl = cfg.ctrl[C_DBL_REQ];
    assign od  = cfg.ctrl[C_OPEN_DR];

    // ------------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------------
    logic [NP-1:0] s1_r, s2_r;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= PIN_I;
            s2_r <= s1_r;
        end
    end

    // ------------------------------------------------------------------
    // Next values of pins and host inputs
    // ------------------------------------------------------------------
    logic [NP-1:0] o_r, o_nxt, oe_n_r, oe_n_nxt;
    logic          cs_r, cs_nxt, a10_r, a10_nxt, ack_r, ack_nxt;
    logic [1:0]    d1, d2;

    always_comb begin
        o_nxt    = cfg.dout;
        oe_n_nxt = ~cfg.ddr; // see R3
        d1 = f_drv(f_pol(dbl ? TRANSMIT_REQUEST_OUT : HOST_REQUEST_OUT,
                         cfg.ctrl[C_REQ_POL]), od);
        d2 = f_drv(f_pol(RECEIVE_REQUEST_OUT, cfg.ctrl[C_REQ_POL]), od);
        cs_nxt  = hen && !mux && f_pol(s2_r[P_B13], cfg.ctrl[C_CS_POL]);
        a10_nxt = hen && mux && s2_r[P_B13]; // see R2
        ack_nxt = hen && !dbl &&
                  f_pol(s2_r[P_B15], cfg.ctrl[C_ACK_POL]); // see R7
        if (hen) begin
            oe_n_nxt[P_B13] = 1'b1; // see R1
            {o_nxt[P_B14], oe_n_nxt[P_B14]} = d1; // see R5, R6
            if (dbl) begin
                {o_nxt[P_B15], oe_n_nxt[P_B15]} = d2; // see R8
            end else begin
                oe_n_nxt[P_B15] = 1'b1; // see R7
            end
        end else if (!mux) begin
            oe_n_nxt[P_B14] = 1'b1; // see R4
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            o_r    <= '0;
            oe_n_r <= OE_OFF; // see R10
            cs_r   <= 1'b0;
            a10_r  <= 1'b0;
            ack_r  <= 1'b0;
        end else begin
            o_r    <= o_nxt;
            oe_n_r <= oe_n_nxt;
            cs_r   <= cs_nxt; // see R1
            a10_r  <= a10_nxt;
            ack_r  <= ack_nxt;
        end
    end

    assign PIN_O               = o_r;
    assign PIN_OE_N            = oe_n_r;
    assign HOST_CHIP_SELECT    = cs_r;
    assign HOST_ADDR_BIT10     = a10_r;
    assign HOST_ACKNOWLEDGE_IN = ack_r;
    assign cfg.stat = {{(DW-NP-3){1'b0}}, ack_r, a10_r, cs_r, s2_r};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_cs;
        @(posedge MCLK) disable iff (!RESET_N)
        (hen && !mux && cfg.ctrl == $past(cfg.ctrl, 3)
         && $past(RESET_N, 3))
        |-> HOST_CHIP_SELECT ==
            ($past(PIN_I[P_B13], 3) ^ ~cfg.ctrl[C_CS_POL]);
    endproperty
    a_cs: assert property (p_cs) // see R1
        else $error("chip select does not follow pin");

    property p_a10;
        @(posedge MCLK) disable iff (!RESET_N)
        (hen && mux && cfg.ctrl == $past(cfg.ctrl, 3)
         && $past(RESET_N, 3))
        |-> HOST_ADDR_BIT10 == $past(PIN_I[P_B13], 3)
            && !HOST_CHIP_SELECT;
    endproperty
    a_a10: assert property (p_a10) // see R2
        else $error("address bit 10 does not follow pin");

    property p_gpio_dir;
        @(posedge MCLK) disable iff (!RESET_N)
        !hen |=> PIN_OE_N[P_B13] == !$past(cfg.ddr[P_B13])
             && PIN_OE_N[P_B15] == !$past(cfg.ddr[P_B15])
             && PIN_O == $past(cfg.dout);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) // see R3
        else $error("general-purpose direction wrong");

    property p_b14;
        @(posedge MCLK) disable iff (!RESET_N)
        (!hen && !mux) |=> PIN_OE_N[P_B14];
    endproperty
    a_b14: assert property (p_b14) // see R4
        else $error("bit 14 driven outside multiplexed mode");

    property p_req;
        @(posedge MCLK) disable iff (!RESET_N)
        (hen && !dbl && !od) |=> !PIN_OE_N[P_B14] && PIN_O[P_B14] ==
            ($past(HOST_REQUEST_OUT) ^ ~$past(cfg.ctrl[C_REQ_POL]));
    endproperty
    a_req: assert property (p_req) // see R5
        else $error("host request pin wrong");

    property p_treq_od;
        @(posedge MCLK) disable iff (!RESET_N)
        (hen && dbl && od) |=> !PIN_O[P_B14] && PIN_OE_N[P_B14] ==
            ($past(TRANSMIT_REQUEST_OUT) ^ ~$past(cfg.ctrl[C_REQ_POL]));
    endproperty
    a_treq_od: assert property (p_treq_od) // see R6
        else $error("transmit request open-drain wrong");

    property p_ack;
        @(posedge MCLK) disable iff (!RESET_N)
        (hen && !dbl) |=> PIN_OE_N[P_B15];
    endproperty
    a_ack: assert property (p_ack) // see R7
        else $error("acknowledge pin driven");

    property p_rreq;
        @(posedge MCLK) disable iff (!RESET_N)
        (hen && dbl && !od) |=> !PIN_OE_N[P_B15] && PIN_O[P_B15] ==
            ($past(RECEIVE_REQUEST_OUT) ^ ~$past(cfg.ctrl[C_REQ_POL]));
    endproperty
    a_rreq: assert property (p_rreq) // see R8
        else $error("receive request pin wrong");

    property p_rst;
        @(posedge MCLK) $rose(RESET_N) |-> &PIN_OE_N;
    endproperty
    a_rst: assert property (p_rst) // see R10
        else $error("pins driven in reset");

    c_cs:   cover property (@(posedge MCLK) disable iff (!RESET_N)
                            $rose(HOST_CHIP_SELECT));
    c_ack:  cover property (@(posedge MCLK) disable iff (!RESET_N)
                            $rose(HOST_ACKNOWLEDGE_IN));
    c_rreq: cover property (@(posedge MCLK) disable iff (!RESET_N)
                            hen && dbl && !PIN_OE_N[P_B15]);
    c_b14:  cover property (@(posedge MCLK) disable iff (!RESET_N)
                            !hen && mux && !PIN_OE_N[P_B14]);

endmodule // hpm_top
`default_nettype wire

// File: logic/hpm_pkg.sv
/*
 * Constants for the host port upper pin mux: register indices, field
 * positions and reset values.
 * Assumes a register port with byte-wide data and word indices as offsets.
 */
`default_nettype none
package hpm_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int AW = 4;
    localparam int DW = 8;
    localparam int NP = 3;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] REG_CTRL = 4'h0;
    localparam logic [AW-1:0] REG_DDR  = 4'h1;
    localparam logic [AW-1:0] REG_DATA = 4'h2;
    localparam logic [AW-1:0] REG_STAT = 4'h3;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int C_HOST_EN = 0;
    localparam int C_MUX_BUS = 1;
    localparam int C_DBL_REQ = 2;
    localparam int C_CS_POL  = 3;
    localparam int C_REQ_POL = 4;
    localparam int C_ACK_POL = 5;
    localparam int C_OPEN_DR = 6;

    // ------------------------------------------------------------------
    // Pin slots and status fields
    // ------------------------------------------------------------------
    localparam int P_B13 = 0;
    localparam int P_B14 = 1;
    localparam int P_B15 = 2;
    localparam int S_CS  = 3;
    localparam int S_A10 = 4;
    localparam int S_ACK = 5;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [DW-1:0] CTRL_RST = 8'h00;
    localparam logic [NP-1:0] DDR_RST  = 3'h0;
    localparam logic [NP-1:0] DATA_RST = 3'h0;
    localparam logic [NP-1:0] OE_OFF   = 3'h7;
    localparam logic [DW-1:0] RD_ZERO  = 8'h00;

endpackage
`default_nettype wire

// File: logic/hpm_cfg_if.sv
/*
 * Carrier between the register file and the pin mux core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface hpm_cfg_if;
    import hpm_pkg::*;
    logic [DW-1:0] ctrl;
    logic [NP-1:0] ddr;
    logic [NP-1:0] dout;
    logic [DW-1:0] stat;
    modport regs (output ctrl, output ddr, output dout, input stat);
    modport core (input ctrl, input ddr, input dout, output stat);
endinterface
`default_nettype wire

// File: logic/hpm_regs.sv
/*
 * Register file of the host port upper pin mux.
 * Assumes one-cycle strobes that never overlap and a master that never
 * waits; read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module hpm_regs
    import hpm_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Register port
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [DW-1:0] rdata,
    // Configuration towards the core
    hpm_cfg_if.regs            cfg
);

    logic [DW-1:0] ctrl_r,  ctrl_nxt;
    logic [NP-1:0] ddr_r,   ddr_nxt;
    logic [NP-1:0] data_r,  data_nxt;
    logic [DW-1:0] rdata_r, rdata_nxt;

    // ------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt  = ctrl_r;
        ddr_nxt   = ddr_r;
        data_nxt  = data_r;
        rdata_nxt = RD_ZERO;
        if (wr) begin
            case (addr)
                REG_CTRL: ctrl_nxt = wdata; // see R9
                REG_DDR:  ddr_nxt  = wdata[NP-1:0]; // see R9
                REG_DATA: data_nxt = wdata[NP-1:0];
                default:  ;
            endcase
        end
        if (rd) begin
            case (addr)
                REG_CTRL: rdata_nxt = ctrl_r;
                REG_DDR:  rdata_nxt = {{(DW-NP){1'b0}}, ddr_r};
                REG_DATA: rdata_nxt = {{(DW-NP){1'b0}}, data_r};
                REG_STAT: rdata_nxt = cfg.stat;
                default:  rdata_nxt = RD_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r  <= CTRL_RST;
            ddr_r   <= DDR_RST;
            data_r  <= DATA_RST;
            rdata_r <= RD_ZERO;
        end else begin
            ctrl_r  <= ctrl_nxt;
            ddr_r   <= ddr_nxt;
            data_r  <= data_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign cfg.ctrl = ctrl_r;
    assign cfg.ddr  = ddr_r;
    assign cfg.dout = data_r;
    assign rdata    = rdata_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_ctrl_wr;
        @(posedge clk) disable iff (!rst_n)
        (wr && addr == REG_CTRL) |=> (cfg.ctrl == $past(wdata));
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) // see R9
        else $error("control write not taken");

    property p_ddr_wr;
        @(posedge clk) disable iff (!rst_n)
        (wr && addr == REG_DDR) |=> (cfg.ddr == $past(wdata[NP-1:0]));
    endproperty
    a_ddr_wr: assert property (p_ddr_wr) // see R9
        else $error("direction write not taken");

endmodule // hpm_regs
`default_nettype wire

// File: tb/hpm_host_model.sv
/*
 * Model of the external host processor on the three upper host port pins.
 * Assumes pull-ups on all three pins and active-low output enables.
 */
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model
    import hpm_pkg::*;
(
    // Device side
    input  wire logic [NP-1:0] pin_o,
    input  wire logic [NP-1:0] pin_oe_n,
    // Host side
    input  wire logic [NP-1:0] drv_en,
    input  wire logic [NP-1:0] drv_val,
    // Resolved pin levels
    output logic      [NP-1:0] pin_lvl
);
    // ------------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------------
    // The host drives select, address or acknowledge; a free pin pulls up.
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            if (!pin_oe_n[i] && drv_en[i]) begin
                pin_lvl[i] = 1'bx;
            end else if (!pin_oe_n[i]) begin
                pin_lvl[i] = pin_o[i];
            end else if (drv_en[i]) begin
                pin_lvl[i] = drv_val[i];
            end else begin
                pin_lvl[i] = 1'b1;
            end
        end
    end
endmodule // hpm_host_model
`default_nettype wire

// File: tb/hpm_tb_top.sv
/*
 * Self-checking testbench of the host port upper pin mux.
 * Assumes the design package and a host model that resolves the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module hpm_tb_top
    import hpm_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic          mclk;
    logic          reset_n;
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic          req;
    logic          trq;
    logic          rrq;
    logic          cs;
    logic          a10;
    logic          ack;
    logic [NP-1:0] pin_lvl;
    logic [NP-1:0] pin_o;
    logic [NP-1:0] pin_oe_n;
    logic [NP-1:0] drv_en;
    logic [NP-1:0] drv_val;
    logic          pol;
    logic          od;
    logic          lv1;
    logic          lv2;
    int            err_total;
    int            checked;
    int            cyc = 0;

    hpm_top dut (
        .MCLK(mclk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .HOST_REQUEST_OUT(req),
        .TRANSMIT_REQUEST_OUT(trq), .RECEIVE_REQUEST_OUT(rrq),
        .HOST_CHIP_SELECT(cs), .HOST_ADDR_BIT10(a10),
        .HOST_ACKNOWLEDGE_IN(ack), .PIN_I(pin_lvl), .PIN_O(pin_o),
        .PIN_OE_N(pin_oe_n)
    );

    hpm_host_model host (
        .pin_o(pin_o), .pin_oe_n(pin_oe_n), .drv_en(drv_en),
        .drv_val(drv_val), .pin_lvl(pin_lvl)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic pins_chk(input logic [2:0] oe, input logic [2:0] o);
        chk({2'b00, pin_oe_n, pin_o & ~oe}, {2'b00, oe, o});
    endtask

    task automatic host_chk(input logic [2:0] e);
        chk({5'h00, ack, a10, cs}, {5'h00, e});
    endtask

    task automatic drive(input logic [2:0] en, input logic [2:0] val,
                         input logic r, input logic t, input logic x);
        @(posedge mclk);
        drv_en  <= en;
        drv_val <= val;
        req     <= r;
        trq     <= t;
        rrq     <= x;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0;
        req = 1'b0; trq = 1'b0; rrq = 1'b0; drv_en = '0; drv_val = '0;
        pol = 1'b0; od = 1'b0; lv1 = 1'b0; lv2 = 1'b0;
        err_total = 0; checked = 0;
        repeat (6) @(posedge mclk);
        #1;
        pins_chk(3'h7, 3'h0);
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        wr_reg(4'hF, 8'hFF);
        rd_chk(REG_CTRL, CTRL_RST);
        rd_chk(REG_DDR, {5'h00, DDR_RST});
        rd_chk(REG_DATA, {5'h00, DATA_RST});
        rd_chk(4'hF, RD_ZERO);
        wr_reg(REG_DDR, 8'h07);
        wr_reg(REG_DATA, 8'h05);
        drive(3'b010, 3'b000, 1'b0, 1'b0, 1'b0);
        pins_chk(3'b010, 3'b101);
        wr_reg(REG_DDR, 8'h04);
        drive(3'b011, 3'b001, 1'b0, 1'b0, 1'b0);
        pins_chk(3'b011, 3'b100);
        wr_reg(REG_STAT, 8'hFF);
        rd_chk(REG_STAT, 8'h05);
        @(posedge mclk);
        #1;
        chk(rdata, RD_ZERO);
        host_chk(3'b000);
        drive(3'b000, 3'b000, 1'b0, 1'b0, 1'b0);
        wr_reg(REG_CTRL, 8'h02);
        wr_reg(REG_DDR, 8'h07);
        wr_reg(REG_DATA, 8'h02);
        drive(3'b000, 3'b000, 1'b0, 1'b0, 1'b0);
        pins_chk(3'b000, 3'b010);
        for (int i = 0; i < 4; i++) begin
            wr_reg(REG_CTRL, i[0] ? 8'h09 : 8'h01);
            drive(3'b001, {2'b00, i[1]}, 1'b0, 1'b0, 1'b0);
            host_chk({2'b00, ~(i[1] ^ i[0])});
        end
        for (int i = 0; i < 2; i++) begin
            wr_reg(REG_CTRL, 8'h03);
            drive(3'b001, {2'b00, i[0]}, 1'b0, 1'b0, 1'b0);
            host_chk({1'b0, i[0], 1'b0});
        end
        for (int i = 0; i < 8; i++) begin
            pol = i[0];
            od  = i[1];
            lv1 = ~(i[2] ^ pol);
            wr_reg(REG_CTRL, {1'b0, od, pol, pol, 4'h1});
            drive(3'b101, {i[2], 2'b01}, i[2], ~i[2], 1'b0);
            pins_chk({1'b1, od & lv1, 1'b1}, {1'b0, ~od & lv1, 1'b0});
            host_chk({lv1, 2'b00});
        end
        drive(3'b001, 3'b001, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 16; i++) begin
            pol = i[0];
            od  = i[1];
            lv1 = ~(i[2] ^ pol);
            lv2 = ~(i[3] ^ pol);
            wr_reg(REG_CTRL, {1'b0, od, 1'b0, pol, 4'h5});
            drive(3'b001, 3'b001, ~i[2], i[2], i[3]);
            pins_chk({od & lv2, od & lv1, 1'b1},
                     {~od & lv2, ~od & lv1, 1'b0});
            host_chk(3'b000);
        end
        wr_reg(REG_CTRL, 8'h15);
        drive(3'b001, 3'b001, 1'b0, 1'b1, 1'b0);
        pins_chk(3'b001, 3'b010);
        @(posedge mclk);
        reset_n <= 1'b0;
        #1;
        pins_chk(3'h7, 3'h0);
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        rd_chk(REG_CTRL, CTRL_RST);
        pins_chk(3'h7, 3'h0);
        results();
    end
endmodule // hpm_tb_top
`default_nettype wire
